//--- sffc_codec_model.sv
// Serial peer model: receive frames toward the block, transmit capture
`timescale 1ns/1ns
`default_nettype none
module sffc_codec_model (
    // Link clock
    input wire logic link_clk_in,
    // Toward the block
    output logic rx_sync_out,
    output logic rx_bit_out,
    output logic tx_sync_out,
    // From the block
    input wire logic tx_bit_in
);
    initial begin
        rx_sync_out = 1'b0;
        rx_bit_out = 1'b0;
        tx_sync_out = 1'b0;
    end

    // sync, gap slots, optional extra sync
    task automatic send(input logic [31:0] w0, input logic [31:0] w1, input int n0, input int n1,
                        input int gap, input bit lsb, input int extra);
        logic b;
        b = 1'b0;
        for (int c = 0; c < gap + n0 + n1; c++) begin
            @(posedge link_clk_in);
            rx_sync_out <= (c == 0) || (c == extra);
            if (c < gap) begin
                rx_bit_out <= ~rx_bit_out;
            end else begin
                b = (c - gap < n0) ? w0[lsb ? c - gap : n0 - 1 - (c - gap)] : w1[n1 - 1 - (c - gap - n0)];
                rx_bit_out <= b;
            end
        end
        // Released line shows the inverse, not a held value
        @(posedge link_clk_in);
        rx_sync_out <= 1'b0;
        rx_bit_out <= ~b;
    endtask : send

    // Transmit bit lags its slot by three link clocks
    task automatic recv(input int n, input int gap, output logic [31:0] w);
        w = '0;
        for (int c = 0; c < gap + n + 3; c++) begin
            @(posedge link_clk_in);
            tx_sync_out <= (c == 0);
            if (c >= gap + 3) begin
                @(negedge link_clk_in);
                w = {w[30:0], tx_bit_in};
            end
        end
    endtask : recv
endmodule : sffc_codec_model
`default_nettype wire

//--- sffc_frame_engine.sv
// Link-side frame engine: sync, data gap, word and phase counting, shifting
`timescale 1ns/1ns
`default_nettype none
module sffc_frame_engine
    import sffc_pkg::*;
(
    // Link clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Settings
    input wire sffc_ctrl_t cfg_in,
    // Serial side
    input wire logic sync_in,
    input wire logic bit_in,
    output logic bit_out,
    // Word side
    input wire logic [31:0] word_in,
    output logic [31:0] word_out,
    output logic done_out,
    output logic act_out,
    output logic restart_out
);
    sffc_eng_state_t st_reg;
    logic [5:0] bit_reg;
    logic [6:0] cnt_reg;
    logic ph2_reg;
    logic [31:0] shf_reg;
    logic [31:0] txw_reg;
    logic start, take, lsb, last_bit, last_word, p_cur;
    logic [5:0] b_cur, nbits, idx;
    logic [6:0] c_cur;
    logic [2:0] wl;
    logic [1:0] dly;
    logic [31:0] base, shf_n, tw;

    always_comb begin
        start = sync_in && (st_reg == ST_IDLE || !cfg_in.fig);
        dly = (cfg_in.dly == SFFC_DLY_RSVD) ? SFFC_DLY_TWO : cfg_in.dly;
        take = start ? (dly == SFFC_DLY_NONE) : (st_reg == ST_DATA);
        b_cur = start ? 6'h00 : bit_reg;
        c_cur = start ? 7'h00 : cnt_reg;
        p_cur = start ? 1'b0 : ph2_reg;
        wl = (cfg_in.dual && p_cur) ? cfg_in.wl2 : cfg_in.wl1;
        nbits = sffc_word_bits(wl);
        last_bit = (b_cur == nbits - 6'h01);
        // Count field is words minus one
        last_word = (c_cur == ((cfg_in.dual && p_cur) ? cfg_in.fl2 : cfg_in.fl1));
        // Lsb companding only at 8 bits; reversal makes any width lsb first
        lsb = cfg_in.rev || (cfg_in.comp == SFFC_COMP_LSB && wl == SFFC_WL_8);
        base = start ? 32'h0000_0000 : shf_reg;
        shf_n = lsb ? (base | (32'(bit_in) << b_cur)) : {base[30:0], bit_in};
        tw = start ? word_in : txw_reg;
        idx = lsb ? b_cur : (nbits - 6'h01 - b_cur);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_reg <= ST_IDLE;
        end else if (take && last_bit && last_word && !(cfg_in.dual && !p_cur)) begin
            st_reg <= ST_IDLE;
        end else if (start) begin
            st_reg <= (dly == SFFC_DLY_TWO) ? ST_GAP : ST_DATA;
        end else if (st_reg == ST_GAP) begin
            st_reg <= ST_DATA;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bit_reg <= 6'h00;
            cnt_reg <= 7'h00;
            ph2_reg <= 1'b0;
        end else if (take) begin
            if (!last_bit) begin
                bit_reg <= b_cur + 6'h01;
                cnt_reg <= c_cur;
                ph2_reg <= p_cur;
            end else if (last_word) begin
                bit_reg <= 6'h00;
                cnt_reg <= 7'h00;
                ph2_reg <= cfg_in.dual && !p_cur;
            end else begin
                bit_reg <= 6'h00;
                cnt_reg <= c_cur + 7'h01;
                ph2_reg <= p_cur;
            end
        end else if (start) begin
            bit_reg <= 6'h00;
            cnt_reg <= 7'h00;
            ph2_reg <= 1'b0;
        end
    end

    // Shifting in both directions
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            shf_reg <= 32'h0000_0000;
            txw_reg <= 32'h0000_0000;
            word_out <= 32'h0000_0000;
            done_out <= 1'b0;
            bit_out <= 1'b0;
        end else if (take) begin
            bit_out <= tw[idx[4:0]];
            if (last_bit) begin
                shf_reg <= 32'h0000_0000;
                word_out <= shf_n;
                done_out <= ~done_out;
                txw_reg <= word_in;
            end else begin
                shf_reg <= shf_n;
                txw_reg <= tw;
            end
        end else if (start) begin
            // Latch at sync so a data gap never sends a stale word
            txw_reg <= word_in;
        end
    end

    // Status toward the register side
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            act_out <= 1'b0;
            restart_out <= 1'b0;
        end else begin
            act_out <= start || (st_reg != ST_IDLE);
            if (sync_in && st_reg != ST_IDLE && !cfg_in.fig) begin
                restart_out <= ~restart_out;
            end
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_gap_one_bit: assert property (
        (start && dly == SFFC_DLY_ONE) |=> (st_reg == ST_DATA && bit_reg == 6'h00))
        else $error("one-bit gap not honoured");
    a_gap_two_bits: assert property (
        (start && dly == SFFC_DLY_TWO) |=> st_reg == ST_GAP ##1 (st_reg == ST_DATA && bit_reg == 6'h00))
        else $error("two-bit gap not honoured");
    a_frame_len_end: assert property (
        (take && !start && last_bit && last_word && !cfg_in.dual) |=> st_reg == ST_IDLE)
        else $error("frame did not end after programmed word count");
    a_word16_len: assert property (
        (st_reg == ST_DATA && bit_reg == 6'h00 && wl == 3'h2 && cfg_in.fig && !cfg_in.dual)
        |-> ##16 (done_out != $past(done_out)))
        else $error("16-bit word not closed after 16 bits");
    a_rev_lsb_first: assert property (
        (take && !start && cfg_in.rev && b_cur == 6'h01) |=> shf_reg[1] == $past(bit_in))
        else $error("reversed word not assembled lsb first");
    a_comp_needs_8bit: assert property (
        (take && !start && !cfg_in.rev && b_cur == 6'h01 && wl != SFFC_WL_8) |=> shf_reg[0] == $past(bit_in))
        else $error("lsb mode applied to a non 8-bit word");
    a_fig_restart: assert property (
        (sync_in && st_reg == ST_DATA && !cfg_in.fig && cfg_in.dly == SFFC_DLY_TWO) |=> st_reg == ST_GAP)
        else $error("sync during frame did not restart");
    a_fig_ignore: assert property (
        (sync_in && st_reg == ST_DATA && cfg_in.fig && !last_bit) |=> bit_reg == $past(bit_reg) + 6'h01)
        else $error("ignored sync disturbed the frame");
    a_dual_phase: assert property (
        (take && !start && last_bit && last_word && cfg_in.dual && !p_cur) |=> (ph2_reg && st_reg == ST_DATA))
        else $error("second phase not entered");
endmodule : sffc_frame_engine
`default_nettype wire

//--- sffc_pkg.sv
// Shared constants, types and helpers for the serial frame format block
package sffc_pkg;

    // Register offsets
    localparam logic [7:0] SFFC_RX_CTRL_OFS = 8'h00;
    localparam logic [7:0] SFFC_TX_CTRL_OFS = 8'h04;
    localparam logic [7:0] SFFC_RX_DATA_OFS = 8'h08;
    localparam logic [7:0] SFFC_TX_DATA_OFS = 8'h0c;
    localparam logic [7:0] SFFC_STATUS_OFS = 8'h10;

    // Control register reset value and writable bits
    localparam logic [31:0] SFFC_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SFFC_CTRL_WMASK = 32'hffff_7ff0;

    // Status bit positions
    localparam int SFFC_ST_RDY = 0;
    localparam int SFFC_ST_OVR = 1;
    localparam int SFFC_ST_PEND = 2;
    localparam int SFFC_ST_RX_ACT = 3;
    localparam int SFFC_ST_TX_ACT = 4;
    localparam int SFFC_ST_RX_RST = 5;
    localparam int SFFC_ST_TX_RST = 6;

    // Field codes
    localparam logic [2:0] SFFC_WL_8 = 3'h0;
    localparam logic [2:0] SFFC_WL_32 = 3'h5;
    localparam logic [1:0] SFFC_COMP_LSB = 2'h1;
    localparam logic [1:0] SFFC_DLY_NONE = 2'h0;
    localparam logic [1:0] SFFC_DLY_ONE = 2'h1;
    localparam logic [1:0] SFFC_DLY_TWO = 2'h2;
    localparam logic [1:0] SFFC_DLY_RSVD = 2'h3;

    // Control register layout, bit 31 first
    typedef struct packed {
        logic dual;
        logic [6:0] fl2;
        logic [2:0] wl2;
        logic [1:0] comp;
        logic fig;
        logic [1:0] dly;
        logic rsvd_hi;
        logic [6:0] fl1;
        logic [2:0] wl1;
        logic rev;
        logic [3:0] rsvd_lo;
    } sffc_ctrl_t;

    // Settings carried into the link domain as one unit
    typedef struct packed {
        sffc_ctrl_t rx;
        sffc_ctrl_t tx;
        logic [31:0] txw;
    } sffc_xfer_t;

    typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_DATA} sffc_eng_state_t;

    // Word length code to bit count; reserved codes fall back to 8
    function automatic logic [5:0] sffc_word_bits(input logic [2:0] code);
        case (code)
            3'h1: return 6'h0c;
            3'h2: return 6'h10;
            3'h3: return 6'h14;
            3'h4: return 6'h18;
            3'h5: return 6'h20;
            default: return 6'h08;
        endcase
    endfunction : sffc_word_bits

endpackage : sffc_pkg

//--- sffc_sync2.sv
// Two flip-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
module sffc_sync2 #(
    parameter int W = 1
) (
    // Clock
    input wire logic clk_in,
    // Data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_in) begin
        meta_reg <= d_in;
        q_out <= meta_reg;
    end
endmodule : sffc_sync2
`default_nettype wire

//--- sffc_top.sv
// Serial frame format control: registers, domain crossing, receive and transmit engines
`timescale 1ns/1ns
`default_nettype none
module sffc_top
    import sffc_pkg::*;
(
    // System
    input wire logic mclk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Serial link
    input wire logic link_clk_in,
    input wire logic rx_sync_in,
    input wire logic rx_bit_in,
    input wire logic tx_sync_in,
    output logic tx_bit_out
);
    // Register side state
    sffc_ctrl_t rx_ctrl_reg;
    sffc_ctrl_t tx_ctrl_reg;
    logic [31:0] tx_word_reg;
    logic [31:0] rx_word_reg;
    logic rdy_reg;
    logic ovr_reg;
    logic rx_rst_flag_reg;
    logic tx_rst_flag_reg;
    sffc_xfer_t snap_reg;
    logic req_reg;
    logic pend_reg;
    logic done_seen_reg;
    logic rx_rst_seen_reg;
    logic tx_rst_seen_reg;

    // Link side state
    sffc_xfer_t link_cfg_reg;
    logic ack_reg;

    // Crossing wires
    logic [4:0] link_s;
    logic [5:0] main_s;
    logic link_rst, link_req, link_rx_sync, link_rx_bit, link_tx_sync;
    logic ack_s, done_s, rx_rst_s, tx_rst_s, rx_act_s, tx_act_s;
    logic [31:0] rx_word_l;
    logic rx_done_l, rx_act_l, tx_act_l, rx_rst_l, tx_rst_l;

    // Strobes and events
    logic wr_rx, wr_tx, wr_txw, wr_st, rd_rxw, new_word, busy;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction : hit

    always_comb begin
        wr_rx = reg_wr_in && hit(reg_addr_in, SFFC_RX_CTRL_OFS);
        wr_tx = reg_wr_in && hit(reg_addr_in, SFFC_TX_CTRL_OFS);
        wr_txw = reg_wr_in && hit(reg_addr_in, SFFC_TX_DATA_OFS);
        wr_st = reg_wr_in && hit(reg_addr_in, SFFC_STATUS_OFS);
        rd_rxw = reg_rd_in && hit(reg_addr_in, SFFC_RX_DATA_OFS);
        new_word = done_s != done_seen_reg;
        busy = pend_reg || (req_reg != ack_s);
    end

    // Pins and handshake into the link domain
    sffc_sync2 #(.W(5)) u_link_sync (
        .clk_in(link_clk_in),
        .d_in({rst_in, req_reg, rx_sync_in, rx_bit_in, tx_sync_in}),
        .q_out(link_s)
    );
    assign {link_rst, link_req, link_rx_sync, link_rx_bit, link_tx_sync} = link_s;

    // Events and levels back to the register side
    sffc_sync2 #(.W(6)) u_main_sync (
        .clk_in(mclk_in),
        .d_in({ack_reg, rx_done_l, rx_rst_l, tx_rst_l, rx_act_l, tx_act_l}),
        .q_out(main_s)
    );
    assign {ack_s, done_s, rx_rst_s, tx_rst_s, rx_act_s, tx_act_s} = main_s;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rx_ctrl_reg <= SFFC_CTRL_RESET;
        end else if (wr_rx) begin
            rx_ctrl_reg <= reg_wdata_in & SFFC_CTRL_WMASK;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tx_ctrl_reg <= SFFC_CTRL_RESET;
        end else if (wr_tx) begin
            tx_ctrl_reg <= reg_wdata_in & SFFC_CTRL_WMASK;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tx_word_reg <= 32'h0000_0000;
        end else if (wr_txw) begin
            tx_word_reg <= reg_wdata_in;
        end
    end

    // Snapshot only while the link has acknowledged, so it never moves mid-capture
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pend_reg <= 1'b0;
            req_reg <= 1'b0;
            snap_reg <= '0;
        end else begin
            if (wr_rx || wr_tx || wr_txw) begin
                pend_reg <= 1'b1;
            end else if (req_reg == ack_s) begin
                pend_reg <= 1'b0;
            end
            if (pend_reg && req_reg == ack_s) begin
                snap_reg <= '{rx: rx_ctrl_reg, tx: tx_ctrl_reg, txw: tx_word_reg};
                req_reg <= ~req_reg;
            end
        end
    end

    // Link side capture of new settings
    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            ack_reg <= 1'b0;
            link_cfg_reg <= '0;
        end else if (link_req != ack_reg) begin
            link_cfg_reg <= snap_reg;
            ack_reg <= link_req;
        end
    end

    sffc_frame_engine u_rx_engine (
        .clk_in(link_clk_in),
        .rst_in(link_rst),
        .cfg_in(link_cfg_reg.rx),
        .sync_in(link_rx_sync),
        .bit_in(link_rx_bit),
        .bit_out(),
        .word_in(32'h0000_0000),
        .word_out(rx_word_l),
        .done_out(rx_done_l),
        .act_out(rx_act_l),
        .restart_out(rx_rst_l)
    );

    // Transmit word repeats until software writes a new one
    sffc_frame_engine u_tx_engine (
        .clk_in(link_clk_in),
        .rst_in(link_rst),
        .cfg_in(link_cfg_reg.tx),
        .sync_in(link_tx_sync),
        .bit_in(1'b0),
        .bit_out(tx_bit_out),
        .word_in(link_cfg_reg.txw),
        .word_out(),
        .done_out(),
        .act_out(tx_act_l),
        .restart_out(tx_rst_l)
    );

    // Received word; link holds it stable for at least eight link clocks
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            done_seen_reg <= 1'b0;
            rx_word_reg <= 32'h0000_0000;
        end else begin
            done_seen_reg <= done_s;
            if (new_word) begin
                rx_word_reg <= rx_word_l;
            end
        end
    end

    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdy_reg <= 1'b0;
            ovr_reg <= 1'b0;
        end else begin
            rdy_reg <= new_word || (rdy_reg && !rd_rxw);
            ovr_reg <= (new_word && rdy_reg && !rd_rxw) || (ovr_reg && !(wr_st && reg_wdata_in[SFFC_ST_OVR]));
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rx_rst_seen_reg <= 1'b0;
            tx_rst_seen_reg <= 1'b0;
            rx_rst_flag_reg <= 1'b0;
            tx_rst_flag_reg <= 1'b0;
        end else begin
            rx_rst_seen_reg <= rx_rst_s;
            tx_rst_seen_reg <= tx_rst_s;
            rx_rst_flag_reg <= (rx_rst_s != rx_rst_seen_reg)
                || (rx_rst_flag_reg && !(wr_st && reg_wdata_in[SFFC_ST_RX_RST]));
            tx_rst_flag_reg <= (tx_rst_s != tx_rst_seen_reg)
                || (tx_rst_flag_reg && !(wr_st && reg_wdata_in[SFFC_ST_TX_RST]));
        end
    end

    // Read data live for exactly the cycle after the strobe
    always_ff @(posedge mclk_in) begin
        if (rst_in || !reg_rd_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            case (reg_addr_in)
                SFFC_RX_CTRL_OFS: reg_rdata_out <= rx_ctrl_reg;
                SFFC_TX_CTRL_OFS: reg_rdata_out <= tx_ctrl_reg;
                SFFC_RX_DATA_OFS: reg_rdata_out <= rx_word_reg;
                SFFC_TX_DATA_OFS: reg_rdata_out <= tx_word_reg;
                SFFC_STATUS_OFS: begin
                    reg_rdata_out <= 32'h0000_0000;
                    reg_rdata_out[SFFC_ST_RDY] <= rdy_reg;
                    reg_rdata_out[SFFC_ST_OVR] <= ovr_reg;
                    reg_rdata_out[SFFC_ST_PEND] <= busy;
                    reg_rdata_out[SFFC_ST_RX_ACT] <= rx_act_s;
                    reg_rdata_out[SFFC_ST_TX_ACT] <= tx_act_s;
                    reg_rdata_out[SFFC_ST_RX_RST] <= rx_rst_flag_reg;
                    reg_rdata_out[SFFC_ST_TX_RST] <= tx_rst_flag_reg;
                end
                default: reg_rdata_out <= 32'h0000_0000;
            endcase
        end
    end

    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_rx_rsvd_zero: assert property (
        (reg_rd_in && reg_addr_in == SFFC_RX_CTRL_OFS) |=> (reg_rdata_out[15] == 1'b0 && reg_rdata_out[3:0] == 4'h0))
        else $error("receive reserved bits read nonzero");
    a_rx_write_mask: assert property (
        wr_rx |=> rx_ctrl_reg == ($past(reg_wdata_in) & SFFC_CTRL_WMASK))
        else $error("receive control write not masked");
    a_tx_write_fields: assert property (
        wr_tx ##1 (reg_rd_in && reg_addr_in == SFFC_TX_CTRL_OFS && !reg_wr_in)
        |=> reg_rdata_out[31:16] == $past(reg_wdata_in, 2) >> 16)
        else $error("transmit upper fields not read back");
    a_tx_rsvd_zero: assert property (
        (reg_rd_in && reg_addr_in == SFFC_TX_CTRL_OFS) |=> (reg_rdata_out[15] == 1'b0 && reg_rdata_out[3:0] == 4'h0))
        else $error("transmit reserved bits read nonzero");
    a_ready_set_wins: assert property (
        new_word |=> rdy_reg)
        else $error("new word lost");
    a_read_one_cycle: assert property (
        !reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
        else $error("read data outside read cycle");
    a_cfg_handshake: assert property (
        (pend_reg && req_reg == ack_s && !wr_rx && !wr_tx && !wr_txw) |=> (!pend_reg && req_reg != $past(req_reg)))
        else $error("pending settings not sent");
endmodule : sffc_top
`default_nettype wire

//--- sffc_top_tb.sv
// Self-checking testbench for the serial frame format block
`timescale 1ns/1ns
`default_nettype none
module sffc_top_tb
    import sffc_pkg::*;
();
    logic mclk, rst, wr_s, rd_s, link, rx_sync, rx_bit, tx_sync, tx_bit;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;

    sffc_top uut (.mclk_in(mclk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .link_clk_in(link),
        .rx_sync_in(rx_sync), .rx_bit_in(rx_bit), .tx_sync_in(tx_sync), .tx_bit_out(tx_bit));
    sffc_codec_model codec (.link_clk_in(link), .rx_sync_out(rx_sync), .rx_bit_out(rx_bit),
        .tx_sync_out(tx_sync), .tx_bit_in(tx_bit));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Link clock offset so its edges never line up with mclk
    initial begin
        link = 1'b0;
        #3;
        forever #80 link = ~link;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // Write then read back with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] dw, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= dw;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : wr_rd

    function automatic int bits(input int code);
        case (code)
            1: return 12;
            2: return 16;
            3: return 20;
            4: return 24;
            5: return 32;
            default: return 8;
        endcase
    endfunction : bits

    // Settings only change while the link side is idle
    task automatic rx_case(input sffc_ctrl_t c, input logic [31:0] w0, input logic [31:0] w1,
                           input int n0, input int n1, input int gap, input bit lsb, input int extra);
        logic [31:0] d;
        wr(SFFC_RX_CTRL_OFS, c);
        rd(SFFC_RX_DATA_OFS, d);
        wr(SFFC_STATUS_OFS, 32'h0000_0062);
        repeat (4) @(posedge link);
        codec.send(w0, w1, n0, n1, gap, lsb, extra);
        // A restarted frame runs past the peer's last bit
        repeat (12) @(posedge link);
        repeat (8) @(posedge mclk);
    endtask : rx_case

    initial begin
        sffc_ctrl_t c;
        logic [31:0] d;
        int n;
        rst = 1'b1;
        wr_s = 1'b0;
        rd_s = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        repeat (12) @(posedge mclk);
        repeat (4) @(posedge link);
        @(posedge mclk);
        rst <= 1'b0;
        rd(SFFC_RX_CTRL_OFS, d);
        chk(d, 32'h0);
        rd(SFFC_TX_CTRL_OFS, d);
        chk(d, 32'h0);
        wr(SFFC_RX_CTRL_OFS, 32'hffff_ffff);
        rd(SFFC_RX_CTRL_OFS, d);
        chk(d, 32'hffff_7ff0);
        wr_rd(SFFC_TX_CTRL_OFS, 32'hffff_ffff, d);
        chk(d, 32'hffff_7ff0);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, d);
        chk(d, 32'h0);
        // Every size and gap code, reserved ones included
        for (int i = 0; i < 8; i++) begin
            c = '0;
            c.wl1 = 3'(i);
            c.dly = 2'(i % 4);
            n = bits(i);
            rx_case(c, 32'hc3a5_9e71, 32'h0, n, 0, (i % 4 == 3) ? 2 : i % 4, 1'b0, -1);
            rd(SFFC_RX_DATA_OFS, d);
            chk(d, 32'hc3a5_9e71 & 32'((64'h1 << n) - 1));
        end
        c = '0;
        c.wl1 = 3'h2;
        c.fl1 = 7'h01;
        rx_case(c, 32'h1234, 32'habcd, 16, 16, 0, 1'b0, -1);
        rd(SFFC_STATUS_OFS, d);
        chk(d & 32'h3, 32'h3);
        rd(SFFC_RX_DATA_OFS, d);
        chk(d, 32'habcd);
        c = '0;
        c.dual = 1'b1;
        c.wl2 = 3'h2;
        c.dly = SFFC_DLY_ONE;
        rx_case(c, 32'h5a, 32'hbeef, 8, 16, 1, 1'b0, -1);
        rd(SFFC_RX_DATA_OFS, d);
        chk(d, 32'hbeef);
        c.dual = 1'b0;
        c.fl2 = 7'h03;
        rx_case(c, 32'h96, 32'h0, 8, 0, 1, 1'b0, -1);
        rd(SFFC_STATUS_OFS, d);
        chk(d & 32'hb, 32'h1);
        // reversal set together with 32-bit and lsb mode
        c = '0;
        c.rev = 1'b1;
        c.wl1 = SFFC_WL_32;
        c.comp = SFFC_COMP_LSB;
        rx_case(c, 32'h8000_0003, 32'h0, 32, 0, 0, 1'b1, -1);
        rd(SFFC_RX_DATA_OFS, d);
        chk(d, 32'h8000_0003);
        c = '0;
        c.comp = SFFC_COMP_LSB;
        rx_case(c, 32'hc1, 32'h0, 8, 0, 0, 1'b1, -1);
        rd(SFFC_RX_DATA_OFS, d);
        chk(d, 32'hc1);
        // Companding codes ignored at 16 bits
        for (int k = 0; k < 4; k++) begin
            c = '0;
            c.wl1 = 3'h2;
            c.comp = 2'(k);
            rx_case(c, 32'h01c3, 32'h0, 16, 0, 0, 1'b0, -1);
            rd(SFFC_RX_DATA_OFS, d);
            chk(d, 32'h01c3);
        end
        for (int f = 0; f < 2; f++) begin
            c = '0;
            c.wl1 = 3'h2;
            c.fig = f[0];
            c.dly = SFFC_DLY_TWO;
            rx_case(c, 32'h7e81, 32'h0, 16, 0, 2, 1'b0, 6);
            rd(SFFC_STATUS_OFS, d);
            chk(d & 32'h20, f ? 32'h0 : 32'h20);
        end
        rd(SFFC_RX_DATA_OFS, d);
        chk(d, 32'h7e81);
        c = '0;
        c.wl1 = 3'h1;
        c.dly = SFFC_DLY_ONE;
        wr(SFFC_TX_CTRL_OFS, c);
        wr(SFFC_TX_DATA_OFS, 32'h0000_0a5c);
        repeat (8) @(posedge link);
        codec.recv(12, 1, d);
        chk(d, 32'h0000_0a5c);
        close_out();
    end
endmodule : sffc_top_tb
`default_nettype wire
